/* smirb_pkg.sv */
// Purpose: Shared constants and types for the monitor/interrupt register bank
// Assumes: 15-bit byte offsets inside the primary register window
// Notes:   Every register is one aligned 32-bit word
//
// Function
// - Monitor sequencer samples three channels continuously
// - Conversion code sits in bits 15..4
// - Current results, then maximum and minimum, consecutive
// - Revision letter in low byte, read-only
// - Offsets 0x7000..0x7fff reserved for unit registers
// - Unused addresses complete, read as zero
// - Pending at 0x7000, enable at 0x7004
// - Sixteen gain (18 bit), offset (16 bit) registers
// - Pending bit reads one when pending
// - Disabled source never sets its pending flag
// - Write one clears; live condition sets again
// - Write zero leaves pending bit unchanged
// - Bits 0..15 digital, bit 24 counter
// - Byte, halfword, word writes act per lane
// - Reset clears every pending bit
// - Bits 16..23, 25..31 read zero, ignore writes
// - Enable bit gates its source's interrupt; the code gates only the pending set, and O_IRQ follows every pending bit
package smirb_pkg;

  // ****************************************
  // Address map
  // ****************************************
  localparam int unsigned ADDR_W        = 15;
  localparam logic [14:0] OFF_TEMP_CUR  = 15'h3200;
  localparam logic [14:0] OFF_CORE_CUR  = 15'h3204;
  localparam logic [14:0] OFF_AUX_CUR   = 15'h3208;
  localparam logic [14:0] OFF_TEMP_MAX  = 15'h3280;
  localparam logic [14:0] OFF_CORE_MAX  = 15'h3284;
  localparam logic [14:0] OFF_AUX_MAX   = 15'h3288;
  localparam logic [14:0] OFF_TEMP_MIN  = 15'h3290;
  localparam logic [14:0] OFF_CORE_MIN  = 15'h3294;
  localparam logic [14:0] OFF_AUX_MIN   = 15'h3298;
  localparam logic [14:0] OFF_FW_REV    = 15'h4000;
  localparam logic [14:0] OFF_WIN_FIRST = 15'h7000;
  localparam logic [14:0] OFF_WIN_LAST  = 15'h7fff;
  localparam logic [14:0] OFF_IRQ_PEND  = 15'h7000;
  localparam logic [14:0] OFF_IRQ_MASK  = 15'h7004;
  localparam logic [14:0] OFF_OFFS_BASE = 15'h70a0;
  localparam logic [14:0] OFF_GAIN_BASE = 15'h70e0;

  // ****************************************
  // Fields and reset values
  // ****************************************
  localparam int unsigned CODE_W        = 12;
  localparam int unsigned CODE_LSB      = 4;
  localparam int unsigned MON_CH        = 3;
  localparam int unsigned NUM_DIO       = 16;
  localparam int unsigned CNT_BIT       = 24;
  localparam int unsigned GAIN_W        = 18;
  localparam int unsigned OFFS_W        = 16;
  localparam logic [31:0] IRQ_IMPL      = 32'h0100_ffff;
  localparam logic [31:0] PEND_RST      = 32'h0000_0000;
  localparam logic [31:0] MASK_RST      = 32'h0000_0000;
  localparam logic [17:0] GAIN_RST      = 18'h0_0000;
  localparam logic [15:0] OFFS_RST      = 16'h0000;
  localparam logic [11:0] CUR_RST       = 12'h000;
  localparam logic [11:0] MAX_RST       = 12'h000;
  localparam logic [11:0] MIN_RST       = 12'hfff;
  localparam logic [1:0]  CH_LAST       = 2'h2;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic [2:0][11:0] cur;
    logic [2:0][11:0] max;
    logic [2:0][11:0] min;
  } smirb_mon_s;

  typedef struct packed {
    logic [14:0] addr;
    logic        wr;
    logic        rd;
    logic [31:0] wdata;
    logic [3:0]  be;
  } smirb_req_s;

  typedef enum logic [2:0] {
    SEQ_IDLE  = 3'b001,
    SEQ_START = 3'b010,
    SEQ_WAIT  = 3'b100
  } smirb_seq_e;

endpackage

/* smirb_mon_seq.sv */
// Purpose: Free-running monitor sequencer with peak and floor tracking
// Assumes: Converter answers each start with one done pulse
// Notes:   Channel 0 temperature, 1 core supply, 2 auxiliary supply
`timescale 1ns/1ps
module smirb_mon_seq (
  // Clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_rst,
  // Converter
  input  wire logic [11:0]            i_conv_code,
  input  wire logic                   i_conv_done,
  output logic                        o_conv_start,
  output logic [1:0]                  o_conv_chan,
  // Results
  output smirb_pkg::smirb_mon_s       o_mon
);

  smirb_pkg::smirb_seq_e state_q, state_d;
  logic [1:0]            chan_q, chan_d;
  logic                  start_q, start_d;
  smirb_pkg::smirb_mon_s mon_q, mon_d;

  // ****************************************
  // Sequencer next state
  // ****************************************
  always_comb begin
    state_d = state_q;
    chan_d  = chan_q;
    start_d = 1'b0;
    mon_d   = mon_q;
    case (state_q)
      smirb_pkg::SEQ_IDLE: begin
        state_d = smirb_pkg::SEQ_START;
      end
      smirb_pkg::SEQ_START: begin
        start_d = 1'b1;
        state_d = smirb_pkg::SEQ_WAIT;
      end
      smirb_pkg::SEQ_WAIT: begin
        if (i_conv_done) begin
          mon_d.cur[chan_q] = i_conv_code;
          if (i_conv_code > mon_q.max[chan_q]) begin
            mon_d.max[chan_q] = i_conv_code;
          end
          if (i_conv_code < mon_q.min[chan_q]) begin
            mon_d.min[chan_q] = i_conv_code;
          end
          // No host step needed to move on
          chan_d  = (chan_q == smirb_pkg::CH_LAST) ? 2'h0 : chan_q + 2'h1;
          state_d = smirb_pkg::SEQ_START;
        end
      end
      default: begin
        state_d = smirb_pkg::SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_q <= smirb_pkg::SEQ_IDLE;
      chan_q  <= 2'h0;
      start_q <= 1'b0;
      mon_q   <= {{3{smirb_pkg::CUR_RST}}, {3{smirb_pkg::MAX_RST}},
                  {3{smirb_pkg::MIN_RST}}};
    end else begin
      state_q <= state_d;
      chan_q  <= chan_d;
      start_q <= start_d;
      mon_q   <= mon_d;
    end
  end

  assign o_conv_start = start_q;
  assign o_conv_chan  = chan_q;
  assign o_mon        = mon_q;

  // ****************************************
  // Checks
  // ****************************************
  default clocking seq_cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence conv_done_s;
    (state_q == smirb_pkg::SEQ_WAIT) && i_conv_done;
  endsequence

  seq_advance_a: assert property (conv_done_s |=> ##1 start_q &&
    (chan_q == (($past(chan_q, 2) == smirb_pkg::CH_LAST) ? 2'h0 : $past(chan_q, 2) + 2'h1)))
    else $error("Sequencer did not restart on the next channel");

  seq_peak_a: assert property (conv_done_s |=>
    (mon_q.max[$past(chan_q)] >= mon_q.cur[$past(chan_q)]) &&
    (mon_q.min[$past(chan_q)] <= mon_q.cur[$past(chan_q)]))
    else $error("Peak or floor not updated with new code");

endmodule // smirb_mon_seq

/* smirb_top.sv */
// Purpose: Monitor results, revision and global interrupt register bank
// Assumes: One access per cycle; reads answered one cycle later
// Notes:   Unit register sets in the window are decoded only, apart from the calibration words
`timescale 1ns/1ps
module smirb_top #(
  parameter logic [7:0] FW_REV_CHAR = 8'h5a, // Value is arbitrary
  parameter int unsigned NUM_CAL    = 16
) (
  // Clock and reset
  input  wire logic        I_CLK,
  input  wire logic        I_RST,
  // Register access
  input  wire logic [14:0] I_ADDR,
  input  wire logic        I_WR,
  input  wire logic        I_RD,
  input  wire logic [31:0] I_WDATA,
  input  wire logic [3:0]  I_BE,
  output logic [31:0]      O_RDATA,
  output logic             O_ACK,
  // Monitor converter
  input  wire logic [11:0] I_CONV_CODE,
  input  wire logic        I_CONV_DONE,
  output logic             O_CONV_START,
  output logic [1:0]       O_CONV_CHAN,
  // Interrupt sources and request
  input  wire logic [15:0] I_DIO_EVT,
  input  wire logic        I_CNT_EVT,
  output logic             O_IRQ
);

  smirb_pkg::smirb_req_s req;
  smirb_pkg::smirb_mon_s mon;
  logic [12:0]           wa;
  logic [31:0]           wmask;
  logic                  hit_pend, hit_mask, hit_rev, hit_mon, in_win;
  logic [NUM_CAL-1:0]    hit_gain, hit_offs;
  logic [31:0]           set_v, clr_v;
  logic [31:0]           pend_q, pend_d, mask_q, mask_d;
  logic [31:0]           rdata_q, rdata_d;
  logic                  ack_q, ack_d, irq_q, irq_d;
  logic [17:0]           gain_q [NUM_CAL];
  logic [17:0]           gain_d [NUM_CAL];
  logic [15:0]           offs_q [NUM_CAL];
  logic [15:0]           offs_d [NUM_CAL];

  // ****************************************
  // Monitor sequencer
  // ****************************************
  smirb_mon_seq u_seq (
    .i_clk        (I_CLK),
    .i_rst        (I_RST),
    .i_conv_code  (I_CONV_CODE),
    .i_conv_done  (I_CONV_DONE),
    .o_conv_start (O_CONV_START),
    .o_conv_chan  (O_CONV_CHAN),
    .o_mon        (mon)
  );

  // ****************************************
  // Decode
  // ****************************************
  assign req   = '{addr: I_ADDR, wr: I_WR, rd: I_RD, wdata: I_WDATA, be: I_BE};
  assign wa    = req.addr[14:2];
  assign wmask = {{8{req.be[3]}}, {8{req.be[2]}}, {8{req.be[1]}}, {8{req.be[0]}}};
  assign hit_pend = (wa == smirb_pkg::OFF_IRQ_PEND[14:2]);
  assign hit_mask = (wa == smirb_pkg::OFF_IRQ_MASK[14:2]);
  assign hit_rev  = (wa == smirb_pkg::OFF_FW_REV[14:2]);
  assign hit_mon  = (wa == smirb_pkg::OFF_TEMP_CUR[14:2]) || (wa == smirb_pkg::OFF_CORE_CUR[14:2])
                 || (wa == smirb_pkg::OFF_AUX_CUR[14:2]);
  // Unit window decoded as a whole; calibration words live here beside pending and enable
  assign in_win   = (wa >= smirb_pkg::OFF_WIN_FIRST[14:2])
                 && (wa <= smirb_pkg::OFF_WIN_LAST[14:2]);

  // ****************************************
  // Calibration words, a gain and an offset per channel
  // ****************************************
  genvar gi;
  for (gi = 0; gi < NUM_CAL; gi++) begin : g_cal
    assign hit_gain[gi] = (wa == smirb_pkg::OFF_GAIN_BASE[14:2] + 13'(gi));
    assign hit_offs[gi] = (wa == smirb_pkg::OFF_OFFS_BASE[14:2] + 13'(gi));
    always_comb begin
      gain_d[gi] = gain_q[gi];
      offs_d[gi] = offs_q[gi];
      if (req.wr && hit_gain[gi]) begin
        gain_d[gi] = (gain_q[gi] & ~wmask[17:0]) | (req.wdata[17:0] & wmask[17:0]);
      end
      if (req.wr && hit_offs[gi]) begin
        offs_d[gi] = (offs_q[gi] & ~wmask[15:0]) | (req.wdata[15:0] & wmask[15:0]);
      end
    end
    always_ff @(posedge I_CLK) begin
      if (I_RST) begin
        gain_q[gi] <= smirb_pkg::GAIN_RST;
        offs_q[gi] <= smirb_pkg::OFFS_RST;
      end else begin
        gain_q[gi] <= gain_d[gi];
        offs_q[gi] <= offs_d[gi];
      end
    end
  end

  // ****************************************
  // Global interrupt pending and enable
  // ****************************************
  // Sources are levels; a held condition keeps re-pending the bit
  assign set_v = {7'h00, I_CNT_EVT, 8'h00, I_DIO_EVT} & mask_q & smirb_pkg::IRQ_IMPL;
  assign clr_v = (req.wr && hit_pend) ? (req.wdata & wmask & smirb_pkg::IRQ_IMPL)
                                      : 32'h0000_0000;

  always_comb begin
    // Set beats clear so an event landing on the clear is kept
    pend_d = ((pend_q & ~clr_v) | set_v) & smirb_pkg::IRQ_IMPL;
    mask_d = mask_q;
    if (req.wr && hit_mask) begin
      mask_d = ((mask_q & ~wmask) | (req.wdata & wmask)) & smirb_pkg::IRQ_IMPL;
    end
    irq_d = |pend_d;
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      pend_q <= smirb_pkg::PEND_RST;
      mask_q <= smirb_pkg::MASK_RST;
      irq_q  <= 1'b0;
    end else begin
      pend_q <= pend_d;
      mask_q <= mask_d;
      irq_q  <= irq_d;
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  always_comb begin
    rdata_d = 32'h0000_0000;
    ack_d   = req.rd || req.wr;
    if (req.rd) begin
      case (req.addr[14:2])
        smirb_pkg::OFF_TEMP_CUR[14:2]: rdata_d = {16'h0000, mon.cur[0], 4'h0};
        smirb_pkg::OFF_CORE_CUR[14:2]: rdata_d = {16'h0000, mon.cur[1], 4'h0};
        smirb_pkg::OFF_AUX_CUR[14:2]:  rdata_d = {16'h0000, mon.cur[2], 4'h0};
        smirb_pkg::OFF_TEMP_MAX[14:2]: rdata_d = {16'h0000, mon.max[0], 4'h0};
        smirb_pkg::OFF_CORE_MAX[14:2]: rdata_d = {16'h0000, mon.max[1], 4'h0};
        smirb_pkg::OFF_AUX_MAX[14:2]:  rdata_d = {16'h0000, mon.max[2], 4'h0};
        smirb_pkg::OFF_TEMP_MIN[14:2]: rdata_d = {16'h0000, mon.min[0], 4'h0};
        smirb_pkg::OFF_CORE_MIN[14:2]: rdata_d = {16'h0000, mon.min[1], 4'h0};
        smirb_pkg::OFF_AUX_MIN[14:2]:  rdata_d = {16'h0000, mon.min[2], 4'h0};
        smirb_pkg::OFF_FW_REV[14:2]:   rdata_d = {24'h00_0000, FW_REV_CHAR};
        smirb_pkg::OFF_IRQ_PEND[14:2]: rdata_d = pend_q;
        smirb_pkg::OFF_IRQ_MASK[14:2]: rdata_d = mask_q;
        default: begin
          // Rest of the unit window decodes; only the calibration words hold data here
          for (int k = 0; k < NUM_CAL; k++) begin
            if (in_win && hit_gain[k]) begin
              rdata_d = {14'h0000, gain_q[k]};
            end
            if (in_win && hit_offs[k]) begin
              rdata_d = {16'h0000, offs_q[k]};
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      rdata_q <= 32'h0000_0000;
      ack_q   <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      ack_q   <= ack_d;
    end
  end

  assign O_RDATA = rdata_q;
  assign O_ACK   = ack_q;
  assign O_IRQ   = irq_q;

  // ****************************************
  // Checks
  // ****************************************
  logic mapped;
  assign mapped = hit_pend || hit_mask || hit_rev || hit_mon || (|hit_gain) || (|hit_offs)
               || (wa == smirb_pkg::OFF_TEMP_MAX[14:2]) || (wa == smirb_pkg::OFF_CORE_MAX[14:2])
               || (wa == smirb_pkg::OFF_AUX_MAX[14:2]) || (wa == smirb_pkg::OFF_TEMP_MIN[14:2])
               || (wa == smirb_pkg::OFF_CORE_MIN[14:2]) || (wa == smirb_pkg::OFF_AUX_MIN[14:2]);

  default clocking top_cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);

  sequence pend_read_s;
    I_RD && hit_pend;
  endsequence

  pend_read_a: assert property (pend_read_s |=> O_ACK && (O_RDATA == $past(pend_q)))
    else $error("Pending read did not return pending bits");
  unimpl_zero_a: assert property (pend_read_s |=> (O_RDATA & ~smirb_pkg::IRQ_IMPL) == 32'h0)
    else $error("Unimplemented pending bits read nonzero");
  mask_gate_a: assert property ((pend_q & ~$past(pend_q) & ~$past(mask_q)) == 32'h0)
    else $error("Disabled source set its pending bit");
  clear_hold_a: assert property (($past(pend_q) & ~$past(clr_v) & ~pend_q) == 32'h0)
    else $error("Pending bit lost without a write of one");
  w1c_clear_a: assert property ((I_WR && hit_pend) |=>
    ((pend_q & $past(clr_v) & ~$past(set_v)) == 32'h0))
    else $error("Write of one did not clear pending bit");
  lane_keep_a: assert property ((I_WR && hit_pend && !I_BE[0]) |=>
    ((pend_q[7:0] & $past(pend_q[7:0])) == $past(pend_q[7:0])))
    else $error("Unselected byte lane changed");
  cnt_bit_a: assert property ((I_CNT_EVT && mask_q[smirb_pkg::CNT_BIT]) |=>
    pend_q[smirb_pkg::CNT_BIT])
    else $error("Counter source did not pend bit 24");
  irq_track_a: assert property (O_IRQ == (|pend_q))
    else $error("Request output disagrees with pending bits");
  reset_clear_a: assert property ($fell(I_RST) |-> (pend_q == 32'h0))
    else $error("Pending bits not zero after reset");
  unmapped_zero_a: assert property ((I_RD && !mapped) |=> O_ACK && (O_RDATA == 32'h0))
    else $error("Unused address read nonzero");
  rev_read_a: assert property ((I_RD && hit_rev) |=> O_RDATA == {24'h00_0000, FW_REV_CHAR})
    else $error("Revision read wrong");
  mon_code_a: assert property ((I_RD && wa == smirb_pkg::OFF_CORE_CUR[14:2]) |=>
    (O_RDATA[3:0] == 4'h0) && (O_RDATA[15:4] == $past(mon.cur[1])))
    else $error("Core supply code misplaced");

  // ****************************************
  // Bus answer checks
  // ****************************************
  sequence bus_req_s;
    I_RD || I_WR;
  endsequence

  sequence bus_answer_s;
    O_ACK;
  endsequence

  ack_pulse_a: assert property (bus_req_s |=> bus_answer_s)
    else $error("Access not acknowledged");

  ack_quiet_a: assert property (!(I_RD || I_WR) |=> !O_ACK && (O_RDATA == 32'h0))
    else $error("Answer without an access");

  win_zero_a: assert property ((I_RD && in_win && !mapped) |=> (O_RDATA == 32'h0))
    else $error("Unit window hole read nonzero");

  temp_read_a: assert property ((I_RD && (wa == smirb_pkg::OFF_TEMP_CUR[14:2])) |=>
    (O_RDATA == {16'h0000, $past(mon.cur[0]), 4'h0}))
    else $error("Temperature code misplaced");

  aux_read_a: assert property ((I_RD && (wa == smirb_pkg::OFF_AUX_CUR[14:2])) |=>
    (O_RDATA[15:4] == $past(mon.cur[2])))
    else $error("Auxiliary supply code misplaced");

  peak_read_a: assert property ((I_RD && (wa == smirb_pkg::OFF_CORE_MAX[14:2])) |=>
    (O_RDATA[15:4] == $past(mon.max[1])))
    else $error("Core supply peak misplaced");

  floor_read_a: assert property ((I_RD && (wa == smirb_pkg::OFF_AUX_MIN[14:2])) |=>
    (O_RDATA[15:4] == $past(mon.min[2])))
    else $error("Auxiliary supply floor misplaced");

  // ****************************************
  // Calibration and interrupt checks
  // ****************************************
  gain_width_a: assert property ((I_RD && (|hit_gain)) |=> (O_RDATA[31:18] == 14'h0))
    else $error("Gain read shows bits above 17");

  offs_width_a: assert property ((I_RD && (|hit_offs)) |=> (O_RDATA[31:16] == 16'h0000))
    else $error("Offset read shows bits above 15");

  gain_read_a: assert property ((I_RD && hit_gain[0]) |=>
    (O_RDATA == {14'h0, $past(gain_q[0])}))
    else $error("Channel 0 gain read wrong");

  mask_read_a: assert property ((I_RD && hit_mask) |=> (O_RDATA == $past(mask_q)))
    else $error("Enable read wrong");

  mask_write_a: assert property ((I_WR && hit_mask && (I_BE == 4'hf)) |=>
    (mask_q == ($past(I_WDATA) & smirb_pkg::IRQ_IMPL)))
    else $error("Enable write not taken");

  mask_lane_a: assert property ((I_WR && hit_mask && !I_BE[1]) |=>
    (mask_q[15:8] == $past(mask_q[15:8])))
    else $error("Unselected enable lane changed");

  pend_lane_a: assert property ((I_WR && hit_pend && !I_BE[3]) |=>
    (pend_q[24] || !$past(pend_q[24])))
    else $error("Counter bit cleared by unselected lane");

  pend_impl_a: assert property ((pend_q & ~smirb_pkg::IRQ_IMPL) == 32'h0)
    else $error("Unimplemented pending bit set");

  dio_low_a: assert property ((I_DIO_EVT[0] && mask_q[0]) |=> pend_q[0])
    else $error("Channel 0 did not pend bit 0");

  dio_high_a: assert property ((I_DIO_EVT[15] && mask_q[15]) |=> pend_q[15])
    else $error("Channel 15 did not pend bit 15");

endmodule // smirb_top

/* smirb_top_tb.sv */
// Purpose: Self-checking bench for the monitor and interrupt register bank
// Assumes: Bench answers the converter; one bus access per cycle
// Notes:   Inputs change at the falling edge; a model tracks pending and enable
`timescale 1ns/1ps
module smirb_top_tb;

  // ****************************************
  // Signals and model state
  // ****************************************
  logic        I_CLK, I_RST, I_WR, I_RD, I_CONV_DONE, I_CNT_EVT;
  logic [14:0] I_ADDR;
  logic [31:0] I_WDATA;
  logic [3:0]  I_BE;
  logic [11:0] I_CONV_CODE;
  logic [15:0] I_DIO_EVT;
  logic [31:0] O_RDATA;
  logic        O_ACK, O_CONV_START, O_IRQ;
  logic [1:0]  O_CONV_CHAN;
  int          n_mismatch = 0;
  int          tests_run  = 0;
  logic [31:0] pend_m, mask_m, lane_m, clr_m;
  logic [11:0] cur_m[3], max_m[3], min_m[3];
  logic        conv_hold = 1'b0;
  // Arbitrary revision letter, not a real part's
  localparam logic [7:0] REV = 8'h6b;

  smirb_top #(.FW_REV_CHAR(REV), .NUM_CAL(16)) DUT (
    .I_CLK(I_CLK), .I_RST(I_RST), .I_ADDR(I_ADDR), .I_WR(I_WR), .I_RD(I_RD),
    .I_WDATA(I_WDATA), .I_BE(I_BE), .O_RDATA(O_RDATA), .O_ACK(O_ACK),
    .I_CONV_CODE(I_CONV_CODE), .I_CONV_DONE(I_CONV_DONE), .O_CONV_START(O_CONV_START),
    .O_CONV_CHAN(O_CONV_CHAN), .I_DIO_EVT(I_DIO_EVT), .I_CNT_EVT(I_CNT_EVT), .O_IRQ(O_IRQ));

  initial I_CLK = 1'b0;
  always #10 I_CLK = ~I_CLK;

  // ****************************************
  // Checking and bus tasks
  // ****************************************
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
      n_mismatch++;
    end
  endtask

  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Strobes stay up between tasks; each access re-drives both and bus_idle drops them
  task automatic bus_wr(input logic [14:0] a, input logic [31:0] d, input logic [3:0] be);
    I_WR = 1'b1; I_RD = 1'b0; I_ADDR = a; I_WDATA = d; I_BE = be;
    @(negedge I_CLK);
    check("write ack", {31'h0, O_ACK}, 32'h1);
  endtask

  task automatic bus_rd(input logic [14:0] a, output logic [31:0] d);
    I_RD = 1'b1; I_WR = 1'b0; I_ADDR = a;
    @(negedge I_CLK);
    check("read ack", {31'h0, O_ACK}, 32'h1);
    d = O_RDATA;
  endtask

  task automatic rd_chk(input string name, input logic [14:0] a, input logic [31:0] exp);
    logic [31:0] d;
    bus_rd(a, d);
    check(name, d, exp);
  endtask

  task automatic bus_idle();
    I_RD = 1'b0; I_WR = 1'b0;
    @(negedge I_CLK);
  endtask

  function automatic logic [31:0] mon_word(input logic [11:0] c);
    return {16'h0000, c, 4'h0};
  endfunction

  task automatic mon_check();
    logic [31:0] d;
    // Freeze the converter so results cannot move under the reads
    conv_hold = 1'b1;
    repeat (12) @(negedge I_CLK);
    for (int k = 0; k < 3; k++) begin
      bus_rd(smirb_pkg::OFF_TEMP_CUR + 15'(4 * k), d);
      check("current", d, mon_word(cur_m[k]));
      bus_rd(smirb_pkg::OFF_TEMP_MAX + 15'(4 * k), d);
      check("peak", d, mon_word(max_m[k]));
      bus_rd(smirb_pkg::OFF_TEMP_MIN + 15'(4 * k), d);
      check("floor", d, mon_word(min_m[k]));
    end
    bus_idle();
    conv_hold = 1'b0;
  endtask

  // ****************************************
  // Interrupt model
  // ****************************************
  always @(posedge I_CLK) begin
    lane_m = {{8{I_BE[3]}}, {8{I_BE[2]}}, {8{I_BE[1]}}, {8{I_BE[0]}}};
    clr_m  = (I_WR && I_ADDR[14:2] == smirb_pkg::OFF_IRQ_PEND[14:2]) ? I_WDATA & lane_m : '0;
    if (I_RST) begin
      pend_m <= '0;
      mask_m <= '0;
    end else begin
      pend_m <= ((pend_m & ~clr_m) | ({7'h0, I_CNT_EVT, 8'h0, I_DIO_EVT} & mask_m))
                & smirb_pkg::IRQ_IMPL;
      if (I_WR && I_ADDR[14:2] == smirb_pkg::OFF_IRQ_MASK[14:2])
        mask_m <= ((mask_m & ~lane_m) | (I_WDATA & lane_m)) & smirb_pkg::IRQ_IMPL;
    end
  end

  always @(negedge I_CLK) begin
    if (!I_RST)
      check("irq", {31'h0, O_IRQ}, {31'h0, |pend_m});
  end

  // ****************************************
  // Converter responder
  // ****************************************
  initial begin
    logic [11:0] code;
    logic [1:0]  ch, exp_ch;
    exp_ch = 2'h0;
    foreach (cur_m[k]) begin
      cur_m[k] = 12'h000; max_m[k] = 12'h000; min_m[k] = 12'hfff;
    end
    forever begin
      @(negedge I_CLK);
      if (I_RST) exp_ch = 2'h0;
      if (O_CONV_START && !I_RST) begin
        ch = O_CONV_CHAN;
        check("channel", {30'h0, ch}, {30'h0, exp_ch});
        exp_ch = (ch == 2'h2) ? 2'h0 : ch + 2'h1;
        while (conv_hold) @(negedge I_CLK);
        repeat ($urandom_range(0, 3)) @(negedge I_CLK);
        code = 12'($urandom);
        I_CONV_DONE = 1'b1;
        I_CONV_CODE = code;
        @(negedge I_CLK);
        I_CONV_DONE = 1'b0;
        I_CONV_CODE = ~code;
        cur_m[ch] = code;
        if (code > max_m[ch]) max_m[ch] = code;
        if (code < min_m[ch]) min_m[ch] = code;
      end
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [31:0] d;
    logic [14:0] unused_a [5];
    void'($urandom(98));
    I_RST = 1'b1; I_WR = 1'b0; I_RD = 1'b0; I_ADDR = '0; I_WDATA = '0; I_BE = '0;
    I_CONV_DONE = 1'b0; I_CONV_CODE = '0; I_DIO_EVT = '0; I_CNT_EVT = 1'b0;
    repeat (8) @(negedge I_CLK);
    I_RST = 1'b0;
    rd_chk("pending reset", smirb_pkg::OFF_IRQ_PEND, 32'h0);
    rd_chk("enable reset", smirb_pkg::OFF_IRQ_MASK, 32'h0);
    // Revision is read-only, letter in the low byte
    bus_rd(smirb_pkg::OFF_FW_REV, d);
    check("revision", {24'h0, d[7:0]}, {24'h0, REV});
    bus_wr(smirb_pkg::OFF_FW_REV, 32'h0, 4'hf);
    bus_rd(smirb_pkg::OFF_FW_REV, d);
    check("revision kept", {24'h0, d[7:0]}, {24'h0, REV});
    // Unused places complete and read zero, writes leave no trace
    unused_a = '{15'h1000, 15'h7008, 15'h7120, 15'h7ffc, 15'h3300};
    foreach (unused_a[i]) begin
      bus_wr(unused_a[i], 32'hffff_ffff, 4'hf);
      rd_chk("unused", unused_a[i], 32'h0);
    end
    // Calibration words, gain reset value then lane-wide write and readback
    for (int n = 0; n < 16; n++) begin
      rd_chk("gain reset", smirb_pkg::OFF_GAIN_BASE + 15'(4 * n), 32'h0);
      d = $urandom;
      bus_wr(smirb_pkg::OFF_GAIN_BASE + 15'(4 * n), d, 4'hf);
      bus_wr(smirb_pkg::OFF_OFFS_BASE + 15'(4 * n), ~d, 4'hf);
      rd_chk("gain", smirb_pkg::OFF_GAIN_BASE + 15'(4 * n), d & 32'h3_ffff);
      rd_chk("offset", smirb_pkg::OFF_OFFS_BASE + 15'(4 * n), ~d & 32'hffff);
    end
    mon_check();
    // Disabled sources stay quiet whatever their condition
    I_DIO_EVT = 16'hffff; I_CNT_EVT = 1'b1;
    repeat (5) bus_idle();
    rd_chk("masked pending", smirb_pkg::OFF_IRQ_PEND, 32'h0);
    // Live condition sets the bit again after a clear, write zero keeps it
    I_DIO_EVT = 16'h0008; I_CNT_EVT = 1'b0;
    bus_wr(smirb_pkg::OFF_IRQ_MASK, 32'hffff_ffff, 4'hf);
    bus_idle();
    bus_wr(smirb_pkg::OFF_IRQ_PEND, 32'h8, 4'hf);
    rd_chk("reasserted", smirb_pkg::OFF_IRQ_PEND, 32'h8);
    I_DIO_EVT = 16'h0;
    bus_wr(smirb_pkg::OFF_IRQ_PEND, 32'h0, 4'hf);
    rd_chk("zero write", smirb_pkg::OFF_IRQ_PEND, 32'h8);
    bus_wr(smirb_pkg::OFF_IRQ_PEND, 32'h8, 4'h1);
    rd_chk("cleared", smirb_pkg::OFF_IRQ_PEND, 32'h0);
    rd_chk("enable bits", smirb_pkg::OFF_IRQ_MASK, smirb_pkg::IRQ_IMPL);
    // Random traffic against the model, byte lanes at random
    repeat (400) begin
      I_DIO_EVT = 16'($urandom & $urandom & $urandom);
      I_CNT_EVT = ($urandom_range(0, 7) == 0);
      case ($urandom_range(0, 4))
        0: bus_wr(smirb_pkg::OFF_IRQ_PEND, $urandom, 4'($urandom));
        1: bus_wr(smirb_pkg::OFF_IRQ_MASK, $urandom, 4'($urandom));
        2: rd_chk("pending", smirb_pkg::OFF_IRQ_PEND, pend_m);
        3: rd_chk("enable", smirb_pkg::OFF_IRQ_MASK, mask_m);
        default: bus_idle();
      endcase
    end
    I_DIO_EVT = 16'h0; I_CNT_EVT = 1'b0;
    bus_idle();
    mon_check();
    // Reset in mid-run with bits pending; converter left parked
    I_DIO_EVT = 16'h8001; I_CNT_EVT = 1'b1;
    bus_wr(smirb_pkg::OFF_IRQ_MASK, 32'hffff_ffff, 4'hf);
    bus_idle();
    bus_rd(smirb_pkg::OFF_IRQ_PEND, d);
    check("pending set", d & 32'h0100_8001, 32'h0100_8001);
    conv_hold = 1'b1;
    I_RST = 1'b1; I_RD = 1'b0; I_DIO_EVT = 16'h0; I_CNT_EVT = 1'b0;
    repeat (8) @(negedge I_CLK);
    I_RST = 1'b0;
    rd_chk("pending after reset", smirb_pkg::OFF_IRQ_PEND, 32'h0);
    rd_chk("enable after reset", smirb_pkg::OFF_IRQ_MASK, 32'h0);
    bus_idle();
    finish_test();
  end

  // ****************************************
  // Watchdog
  // ****************************************
  // Run needs under 600 cycles; over thirty times that means a hang
  initial begin
    repeat (20000) @(posedge I_CLK);
    n_mismatch++;
    finish_test();
  end

endmodule // smirb_top_tb
